// ### sbcrc_top.sv
/*
  sbcrc_top: standby mode sequencer, wake-up timing, and per-peripheral
  glitch-free clock gates plus block resets for four register pairs.
  Assumes software keeps the reset-then-gate / ungate-then-release order,
  and that peripheral clocks are derived from sys_clk.
*/
// Contract
// RL1 - cpu, dma stop; stop modes stop peripherals
// RL2 - stop modes disable interrupt input sampling
// RL3 - high-speed peripherals idle in high-speed halt
// RL4 - dac holds output through standby
// RL5 - supervisor keeps reset only in stop
// RL6 - wake times: ls 250us, pll 30us/2.5ms
// RL7 - setting 00 masks pll 2.5ms
// RL8 - setting 01 supplies ramping pll immediately
// RL9 - hold cpu until high-speed clock supplied
// RL10 - gate bit stops peripheral clock
// RL11 - reset bit holds peripheral in reset
// RL12 - after reset all clocks on, resets off
// RL13 - software resets before gating clock
// RL14 - software ungates before releasing reset
// RL15 - reset allowed while clock runs
// RL16 - gated or reset peripheral ignores writes
// RL17 - pair mapping of peripherals
// RL18 - stop entry needs unlock codes
// RL19 - high-speed halt exit forces hs clock
// RL20 - gates change only while clock low
`timescale 1ns/1ps
`default_nettype none

module sbcrc_top (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // software control and peripheral write requests
  input  wire sbcrc_pkg::sbcrc_req_s   sb_req,
  input  wire logic                    stop_code_wr,
  input  wire logic [7:0]              stop_code,
  input  wire logic [7:0]              hs_wakeup_time_setting,
  input  wire logic                    sel_hs_system_clock,
  input  wire logic [31:0]             block_clock_gate_reg,
  input  wire logic [31:0]             block_reset_reg,
  input  wire logic [31:0]             periph_wr_req,
  // wake sources, asynchronous
  input  wire logic                    wake_stop_irq,
  input  wire logic                    wake_halt_irq,
  // status and controls out
  output sbcrc_pkg::sbcrc_run_s        run,
  output logic                         hs_osc_force_on,
  output logic                         hs_clk_avail,
  output logic                         pll_ramping,
  output logic [2:0]                   standby_state,
  // peripherals
  output logic [31:0]                  periph_clk,
  output logic [31:0]                  periph_rst,
  output logic [31:0]                  periph_wr_ok
);

  // two-flop synchronisers for wake sources
  logic [1:0] wsync_stop_q;
  logic [1:0] wsync_halt_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wsync_stop_q <= 2'h0;
      wsync_halt_q <= 2'h0;
    end else begin
      wsync_stop_q <= {wsync_stop_q[0], wake_stop_irq};
      wsync_halt_q <= {wsync_halt_q[0], wake_halt_irq};
    end
  end
  logic wake_stop;
  logic wake_halt;
  assign wake_stop = wsync_stop_q[1];
  assign wake_halt = wsync_halt_q[1] | wsync_stop_q[1];

  // standby sequencer state
  sbcrc_pkg::sbcrc_state_e st_q, st_d;
  logic                          unlock1_q, unlock1_d;
  logic                          armed_q, armed_d;
  logic                          deep_q, deep_d;
  logic                          hs_wait_q, hs_wait_d;
  logic                          ramp_q, ramp_d;
  logic [sbcrc_pkg::WAKE_CNT_W-1:0] cnt_q, cnt_d;
  logic                          force_hs_q, force_hs_d;
  logic [sbcrc_pkg::WAKE_CNT_W-1:0] hs_wake_cyc;
  logic                          hs_masked_mode;

  // masked mode for 00, ramp otherwise
  assign hs_masked_mode = (hs_wakeup_time_setting == sbcrc_pkg::HS_WAKEUP_MASKED); // RL7
  assign hs_wake_cyc = hs_masked_mode ?
    sbcrc_pkg::WAKE_CNT_W'(sbcrc_pkg::PLL_SLOW_WAKE_CYC) :
    sbcrc_pkg::WAKE_CNT_W'(sbcrc_pkg::PLL_FAST_WAKE_CYC); // RL6

  // next-state logic for standby modes and wake timers
  always_comb begin
    st_d       = st_q;
    unlock1_d  = unlock1_q;
    armed_d    = armed_q;
    deep_d     = deep_q;
    hs_wait_d  = hs_wait_q;
    ramp_d     = ramp_q;
    cnt_d      = cnt_q;
    force_hs_d = force_hs_q;
    // unlock sequence: first code then second code
    if (stop_code_wr) begin
      if (stop_code[7:4] == sbcrc_pkg::STOP_CODE_FIRST) begin
        unlock1_d = 1'b1;
      end else if (unlock1_q && stop_code[7:4] == sbcrc_pkg::STOP_CODE_SECOND) begin
        armed_d   = 1'b1; // RL18
        unlock1_d = 1'b0;
      end else begin
        unlock1_d = 1'b0;
      end
    end
    // ramp flag lasts for the slow wake window after a ramp-mode wake
    if (ramp_q) begin
      if (cnt_q == '0) begin
        ramp_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
    unique case (st_q)
      sbcrc_pkg::SB_RUN: begin
        if ((sb_req.stop || sb_req.deep_stop) && armed_q) begin
          st_d    = sbcrc_pkg::SB_STOP;
          deep_d  = sb_req.deep_stop;
          armed_d = 1'b0;
        end else if (sb_req.halt_hs) begin
          st_d = sbcrc_pkg::SB_HALT_HS;
        end else if (sb_req.halt) begin
          st_d = sbcrc_pkg::SB_HALT;
        end
      end
      sbcrc_pkg::SB_HALT: begin
        if (wake_halt) begin
          st_d = sbcrc_pkg::SB_RUN;
        end
      end
      sbcrc_pkg::SB_HALT_HS: begin
        if (wake_halt) begin
          force_hs_d = 1'b1; // RL19
          st_d       = sbcrc_pkg::SB_WAKE_HS;
          cnt_d      = hs_wake_cyc;
          ramp_d     = 1'b0;
        end
      end
      sbcrc_pkg::SB_STOP: begin
        if (wake_stop) begin
          st_d  = sbcrc_pkg::SB_WAKE_LS;
          cnt_d = sbcrc_pkg::WAKE_CNT_W'(sbcrc_pkg::LS_WAKE_CYC); // RL6
          ramp_d = 1'b0;
        end
      end
      sbcrc_pkg::SB_WAKE_LS: begin
        if (cnt_q == '0) begin
          st_d      = sbcrc_pkg::SB_RUN;
          deep_d    = 1'b0;
          hs_wait_d = 1'b1;
          cnt_d     = hs_wake_cyc;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      sbcrc_pkg::SB_WAKE_HS: begin
        // cpu held in masked mode; ramp mode goes at once
        if (!hs_masked_mode) begin
          st_d   = sbcrc_pkg::SB_RUN; // RL8
          ramp_d = 1'b1;
          cnt_d  = sbcrc_pkg::WAKE_CNT_W'(sbcrc_pkg::PLL_SLOW_WAKE_CYC);
        end else if (cnt_q == '0) begin
          st_d = sbcrc_pkg::SB_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = sbcrc_pkg::SB_RUN;
    endcase
    // pll still waking after stop; counts alongside run
    if (hs_wait_q && st_q == sbcrc_pkg::SB_RUN) begin
      if (!hs_masked_mode) begin
        hs_wait_d = 1'b0;
        ramp_d    = 1'b1;
        cnt_d     = sbcrc_pkg::WAKE_CNT_W'(sbcrc_pkg::PLL_SLOW_WAKE_CYC);
      end else if (cnt_q == '0) begin
        hs_wait_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
    if (st_q == sbcrc_pkg::SB_RUN && !hs_wait_q && !sel_hs_system_clock) begin
      force_hs_d = 1'b0;
    end
  end

  // standby sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q       <= sbcrc_pkg::SB_RUN;
      unlock1_q  <= 1'b0;
      armed_q    <= 1'b0;
      deep_q     <= 1'b0;
      hs_wait_q  <= 1'b0;
      ramp_q     <= 1'b0;
      cnt_q      <= '0;
      force_hs_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      unlock1_q  <= unlock1_d;
      armed_q    <= armed_d;
      deep_q     <= deep_d;
      hs_wait_q  <= hs_wait_d;
      ramp_q     <= ramp_d;
      cnt_q      <= cnt_d;
      force_hs_q <= force_hs_d;
    end
  end

  logic in_stop;
  logic in_standby;
  logic hs_ready;
  assign in_stop    = (st_q == sbcrc_pkg::SB_STOP) || (st_q == sbcrc_pkg::SB_WAKE_LS);
  assign in_standby = (st_q != sbcrc_pkg::SB_RUN);
  // high-speed clock absent while masked after a stop wake
  assign hs_ready   = !hs_wait_q && st_q != sbcrc_pkg::SB_WAKE_HS && !in_stop; // RL7

  // per-function enables
  always_comb begin
    run.cpu_run           = !in_standby && !(sel_hs_system_clock && !hs_ready); // RL1 RL9
    run.dma_run           = !in_standby; // RL1
    run.periph_run        = !in_stop; // RL1
    run.hs_periph_run     = !in_stop && st_q != sbcrc_pkg::SB_HALT_HS; // RL3
    run.ext_int_sample_en = !in_stop; // RL2
    run.cmp_sample_en     = !in_stop; // RL2
    run.vls_sample_en     = !in_stop; // RL2
    run.vls_int_en        = !in_stop; // RL5
    run.dac_hold          = in_standby; // RL4
    run.vddl_low          = in_stop && deep_q;
  end

  assign hs_osc_force_on = force_hs_q; // RL19
  assign hs_clk_avail    = hs_ready;
  assign pll_ramping     = ramp_q; // RL8
  assign standby_state   = st_q;

  // functions that stop in stop modes; of these only dma also stops in plain halt
  logic [31:0] stop_mask;
  always_comb begin
    stop_mask = 32'hFFFFFFFF; // timers, i2c, serial, crc, md, buzzer
    stop_mask[3*sbcrc_pkg::PAIR_W +: sbcrc_pkg::PAIR_W] = 8'h00; // adc/dac/cmp own their clocks
    stop_mask[2*sbcrc_pkg::PAIR_W + sbcrc_pkg::P2_DMA] = 1'b1;
  end

  // gate enables, sampled on falling edge so changes land while clock low
  logic [31:0] gate_en_q, gate_en_d;
  logic [31:0] rst_q, rst_d;
  always_comb begin
    gate_en_d = ~block_clock_gate_reg; // RL10 RL17
    if (in_stop) begin
      gate_en_d = gate_en_d & ~stop_mask; // RL1
    end
    if (in_standby) begin
      gate_en_d[2*sbcrc_pkg::PAIR_W + sbcrc_pkg::P2_DMA] = 1'b0; // RL1
    end
    if (st_q == sbcrc_pkg::SB_HALT_HS) begin
      gate_en_d[1*sbcrc_pkg::PAIR_W + sbcrc_pkg::P1_I2CM] = 1'b0; // RL3
    end
    rst_d = block_reset_reg; // RL11 RL15
  end

  always_ff @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_en_q <= 32'hFFFFFFFF; // RL12
    end else begin
      gate_en_q <= gate_en_d; // RL20
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_q <= 32'h00000000; // RL12
    end else begin
      rst_q <= rst_d;
    end
  end

  // enable only changes while sys_clk is low, so and-gating is clean
  assign periph_clk   = {32{sys_clk}} & gate_en_q; // RL20
  assign periph_rst   = rst_q; // RL11
  assign periph_wr_ok = periph_wr_req & gate_en_q & ~rst_q; // RL16

endmodule

`default_nettype wire

// ### sbcrc_pkg.sv
/*
  sbcrc_pkg: constants and carrier types for the standby, clock-gating
  and block-reset controller.
  Assumes a 125 MHz system clock; no bus, all control bits are ports.
*/
package sbcrc_pkg;

  // clock rate and wake-up times
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned LS_WAKE_US       = 250;
  localparam int unsigned PLL_FAST_WAKE_US = 30;
  localparam int unsigned PLL_SLOW_WAKE_US = 2500;
  localparam int unsigned LS_WAKE_CYC       = LS_WAKE_US * CLK_MHZ;
  localparam int unsigned PLL_FAST_WAKE_CYC = PLL_FAST_WAKE_US * CLK_MHZ;
  localparam int unsigned PLL_SLOW_WAKE_CYC = PLL_SLOW_WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_CNT_W        = 20;

  // wake-up time setting codes
  localparam logic [7:0] HS_WAKEUP_MASKED = 8'h00;
  localparam logic [7:0] HS_WAKEUP_RAMP   = 8'h01;

  // stop code acceptor unlock codes (upper nibble)
  localparam logic [3:0] STOP_CODE_FIRST  = 4'h5;
  localparam logic [3:0] STOP_CODE_SECOND = 4'hA;

  // gating / reset register pairs
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned PAIR_W    = 8;
  localparam logic [7:0] PAIR_RST_VAL = 8'h00;

  // bit positions: pair 0 timers 0..5; pair 1 ftm 0..3, i2c master 4, i2c unit 5
  // pair 2: serial 0, serial 1, crc 2, muldiv 3, buzzer 4, dma 5
  localparam int unsigned P2_CRC = 2;
  localparam int unsigned P2_MD  = 3;
  localparam int unsigned P2_BUZ = 4;
  localparam int unsigned P2_DMA = 5;
  // pair 3: adc 0, dac 1, comparator 2
  localparam int unsigned P3_DAC = 1;
  localparam int unsigned P1_I2CM = 4;

  typedef enum logic [2:0] {
    SB_RUN     = 3'b000,
    SB_HALT    = 3'b001,
    SB_HALT_HS = 3'b010,
    SB_STOP    = 3'b011,
    SB_WAKE_LS = 3'b100,
    SB_WAKE_HS = 3'b101
  } sbcrc_state_e;

  // standby request carrier
  typedef struct packed {
    logic halt;
    logic halt_hs;
    logic stop;
    logic deep_stop;
  } sbcrc_req_s;

  // per-function run enables toward the chip
  typedef struct packed {
    logic cpu_run;
    logic dma_run;
    logic periph_run;
    logic hs_periph_run;
    logic ext_int_sample_en;
    logic cmp_sample_en;
    logic vls_sample_en;
    logic vls_int_en;
    logic dac_hold;
    logic vddl_low;
  } sbcrc_run_s;

endpackage

// ### sbcrc_chk_sva.sv
/*
  sbcrc_chk: port-level assertions for the standby controller.
  Bound to sbcrc_top from tb_top; it sees only the top module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sbcrc_chk (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // controls
  input wire logic                  wake_halt_irq,
  input wire logic                  sel_hs_system_clock,
  // outputs watched
  input wire sbcrc_pkg::sbcrc_run_s run,
  input wire logic                  hs_osc_force_on,
  input wire logic                  hs_clk_avail,
  input wire logic [2:0]            standby_state,
  input wire logic [31:0]           periph_rst,
  input wire logic [31:0]           periph_wr_ok,
  input wire logic [31:0]           periph_clk
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [19:0] ls_cnt_q;
  logic [19:0] ls_cnt_d;
  // cycles spent in low-speed wake; counted here because the wait is far too long to unroll
  always_comb ls_cnt_d = (standby_state == 3'h4) ? ls_cnt_q + 20'h1 : 20'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ls_cnt_q <= 20'h0;
    end else begin
      ls_cnt_q <= ls_cnt_d;
    end
  end
  cpu_stop_a: assert property (standby_state inside {3'h1, 3'h2, 3'h3} |-> !run.cpu_run && !run.dma_run)
    else $error("cpu or dma running in standby");
  stop_periph_a: assert property (standby_state == 3'h3 |-> !run.periph_run)
    else $error("peripherals running in stop");
  halt_run_a: assert property (standby_state == 3'h1 |-> run.periph_run && run.hs_periph_run)
    else $error("peripherals stopped in halt");
  sample_off_a: assert property (standby_state == 3'h3 |-> !run.ext_int_sample_en && !run.cmp_sample_en)
    else $error("input sampling left on in stop");
  hs_idle_a: assert property (standby_state == 3'h2 |-> !run.hs_periph_run)
    else $error("high-speed peripherals running in high-speed halt");
  dac_hold_a: assert property (standby_state inside {3'h1, 3'h2, 3'h3} |-> run.dac_hold)
    else $error("dac not held in standby");
  vls_int_a: assert property (standby_state == 3'h3 |-> !run.vls_int_en && !run.vls_sample_en)
    else $error("supervisor interrupt or sampling on in stop");
  ls_wait_a: assert property (standby_state == 3'h4 ##1 standby_state != 3'h4 |-> ls_cnt_q inside {[20'h07A0F:20'h07A15]})
    else $error("low-speed wake time wrong");
  hs_exit_a: assert property (standby_state == 3'h2 ##1 standby_state != 3'h2 |-> ##[0:2] hs_osc_force_on)
    else $error("high-speed oscillator not forced on");
  cpu_hold_a: assert property (standby_state == 3'h0 && sel_hs_system_clock && !hs_clk_avail |-> !run.cpu_run)
    else $error("cpu runs before high-speed clock");
  halt_wake_a: assert property (standby_state == 3'h1 && wake_halt_irq |-> ##[1:6] standby_state == 3'h0)
    else $error("halt not released");
  rst_rel_a: assert property ($past(rst) |-> periph_rst == 32'h0)
    else $error("block reset active after reset");
  wr_block_a: assert property ((periph_wr_ok & periph_rst) == 32'h0)
    else $error("write allowed to peripheral in reset");
  // sampled just before the rising edge, so every gated clock must be low here
  clk_low_a: assert property (periph_clk == 32'h0)
    else $error("gated clock high in low phase");
  // main scenarios reached
  stop_c: cover property (standby_state == 3'h3);
  halths_c: cover property (standby_state == 3'h2);
  lswake_c: cover property (standby_state == 3'h4 ##1 standby_state == 3'h0);
  hsmask_c: cover property (standby_state == 3'h5 ##1 standby_state == 3'h5);
endmodule
`default_nettype wire

// ### sbcrc_periph_model.sv
/*
  sbcrc_periph_model: the peripheral blocks behind the gates.
  Records an edge on each gated clock; bench clears the record.
*/
`timescale 1ns/1ps
`default_nettype none
module sbcrc_periph_model (
  // gated clocks in
  input  wire logic [31:0] periph_clk,
  // bench controls
  input  wire logic        clr,
  input  wire logic        wr_en,
  // toward controller and bench
  output logic      [31:0] periph_wr_req,
  output logic      [31:0] clk_seen
);
  // all peripherals try to write while the bench asks, so refusals show
  assign periph_wr_req = {32{wr_en}};
  // one edge catcher per peripheral; a gated clock leaves its bit clear
  for (genvar i = 0; i < 32; i++) begin : g_p
    logic seen_q;
    always @(posedge periph_clk[i] or posedge clr) begin
      if (clr) begin
        seen_q <= 1'b0;
      end else begin
        seen_q <= 1'b1;
      end
    end
    assign clk_seen[i] = seen_q;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
/*
  tb_top: directed scenarios for the standby controller.
  Inputs change 1 ns after each rising edge; sbcrc_periph_model stands behind the gates.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic                  sys_clk = 1'b0;
  logic                  rst     = 1'b1;
  sbcrc_pkg::sbcrc_req_s req     = '0;
  logic                  code_wr = 1'b0;
  logic [7:0]            code    = 8'h00;
  logic                  hs_sel  = 1'b0;
  logic [7:0]            hs_set  = 8'h01;
  logic [31:0]           gate    = 32'h0;
  logic [31:0]           brst    = 32'h0;
  logic                  ws      = 1'b0;
  logic                  wh      = 1'b0;
  logic                  clr     = 1'b0;
  logic [31:0]           wr_req, seen, pclk, prst, wr_ok;
  sbcrc_pkg::sbcrc_run_s run;
  logic                  force_on, hs_av, ramp;
  logic [2:0]            st;
  int                    failures    = 0;
  int                    checks_done = 0;
  // 125 MHz
  initial forever #4 sys_clk = ~sys_clk;
  sbcrc_top u_dut (.sys_clk(sys_clk), .rst(rst), .sb_req(req), .stop_code_wr(code_wr), .stop_code(code),
    .hs_wakeup_time_setting(hs_set), .sel_hs_system_clock(hs_sel), .block_clock_gate_reg(gate),
    .block_reset_reg(brst), .periph_wr_req(wr_req), .wake_stop_irq(ws), .wake_halt_irq(wh), .run(run),
    .hs_osc_force_on(force_on), .hs_clk_avail(hs_av), .pll_ramping(ramp), .standby_state(st),
    .periph_clk(pclk), .periph_rst(prst), .periph_wr_ok(wr_ok));
  sbcrc_periph_model u_model (.periph_clk(pclk), .clr(clr), .wr_en(1'b1), .periph_wr_req(wr_req),
    .clk_seen(seen));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for a state; running out ends the run
  task automatic wait_st(input logic [2:0] s, input int lim, output int n);
    n = 0;
    while (st !== s && n < lim) begin
      step(1);
      n++;
    end
    `CHK("standby_state", s, st)
    if (st !== s) complete_run();
  endtask
  task automatic seen_chk(input logic [31:0] e);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(3);
    `CHK("clk_seen", e, seen)
  endtask
  // code strobe held high across the whole sequence
  task automatic unlock(input logic [7:0] mid);
    code_wr = 1'b1;
    code = 8'h53;
    step(1);
    if (mid != 8'h00) begin
      code = mid;
      step(1);
    end
    code = 8'hA7;
    step(1);
    code_wr = 1'b0;
  endtask
  task automatic t_reset();
    `CHK("periph_rst", 32'h0, prst)
    `CHK("periph_wr_ok", 32'hFFFFFFFF, wr_ok)
    `CHK("run", 10'h3FC, run)
    seen_chk(32'hFFFFFFFF);
    $display("test reset done");
  endtask
  // second reset in mid-run; also ends a masked pll wait that would outlast the run
  task automatic mid_reset();
    hs_sel = 1'b0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    `CHK("standby_state", 3'h0, st)
    `CHK("hs_osc_force_on", 1'b0, force_on)
    t_reset();
  endtask
  // timer0, i2c master, dma, dac: one bit in each pair
  task automatic t_gate();
    brst = 32'h0220_1001;
    step(2);
    `CHK("periph_rst", 32'h0220_1001, prst)
    `CHK("periph_wr_ok", ~32'h0220_1001, wr_ok)
    seen_chk(32'hFFFFFFFF);
    gate = 32'h0220_1001;
    step(2);
    seen_chk(~32'h0220_1001);
    gate = 32'h0;
    step(2);
    brst = 32'h0;
    step(2);
    `CHK("periph_wr_ok", 32'hFFFFFFFF, wr_ok)
    seen_chk(32'hFFFFFFFF);
    $display("test gate done");
  endtask
  task automatic t_stop();
    int n;
    hs_set = 8'h00;
    hs_sel = 1'b1;
    req.stop = 1'b1;
    step(3);
    `CHK("standby_state", 3'h0, st)
    req.stop = 1'b0;
    unlock(8'h37);
    req.deep_stop = 1'b1;
    step(3);
    `CHK("standby_state", 3'h0, st)
    req.deep_stop = 1'b0;
    unlock(8'h00);
    req.deep_stop = 1'b1;
    wait_st(3'h3, 4, n);
    req.deep_stop = 1'b0;
    `CHK("cpu_run", 1'b0, run.cpu_run)
    `CHK("periph_run", 1'b0, run.periph_run)
    `CHK("ext_int_sample_en", 1'b0, run.ext_int_sample_en)
    `CHK("vls_int_en", 1'b0, run.vls_int_en)
    `CHK("dac_hold", 1'b1, run.dac_hold)
    `CHK("vddl_low", 1'b1, run.vddl_low)
    seen_chk(32'hFF00_0000);
    ws = 1'b1;
    wait_st(3'h4, 8, n);
    ws = 1'b0;
    wait_st(3'h0, 31300, n);
    `CHK("ls_wake", 1'b1, (n + 3 >= int'(sbcrc_pkg::LS_WAKE_CYC)) && (n <= int'(sbcrc_pkg::LS_WAKE_CYC) + 3))
    // masked pll still waking: no high-speed clock, so the cpu waits on it
    `CHK("hs_clk_avail", 1'b0, hs_av)
    `CHK("cpu_run", 1'b0, run.cpu_run)
    hs_sel = 1'b0;
    step(1);
    `CHK("cpu_run", 1'b1, run.cpu_run)
    mid_reset();
    hs_set = 8'h01;
    $display("test stop done");
  endtask
  task automatic t_halt();
    int n;
    req.halt = 1'b1;
    wait_st(3'h1, 4, n);
    req.halt = 1'b0;
    `CHK("cpu_run", 1'b0, run.cpu_run)
    `CHK("periph_run", 1'b1, run.periph_run)
    seen_chk(~32'h0020_0000);
    wh = 1'b1;
    wait_st(3'h0, 8, n);
    wh = 1'b0;
    // let the synchroniser drain so the next halt is not woken at once
    step(3);
    $display("test halt done");
  endtask
  task automatic t_halths();
    int n;
    hs_sel = 1'b1;
    req.halt_hs = 1'b1;
    wait_st(3'h2, 4, n);
    req.halt_hs = 1'b0;
    `CHK("hs_periph_run", 1'b0, run.hs_periph_run)
    `CHK("periph_run", 1'b1, run.periph_run)
    `CHK("pll_ramping", 1'b0, ramp)
    seen_chk(~32'h0020_1000);
    wh = 1'b1;
    wait_st(3'h0, 12, n);
    wh = 1'b0;
    step(3);
    `CHK("hs_osc_force_on", 1'b1, force_on)
    `CHK("pll_ramping", 1'b1, ramp)
    $display("test halt_hs done");
  endtask
  // masked wake holds the cpu far longer than the run; a reset ends the wait
  task automatic t_halths_masked();
    int n;
    hs_sel = 1'b0;
    step(2);
    `CHK("hs_osc_force_on", 1'b0, force_on)
    hs_set = 8'h00;
    hs_sel = 1'b1;
    req.halt_hs = 1'b1;
    wait_st(3'h2, 4, n);
    req.halt_hs = 1'b0;
    wh = 1'b1;
    wait_st(3'h5, 8, n);
    wh = 1'b0;
    `CHK("hs_clk_avail", 1'b0, hs_av)
    `CHK("cpu_run", 1'b0, run.cpu_run)
    `CHK("hs_osc_force_on", 1'b1, force_on)
    step(100);
    `CHK("standby_state", 3'h5, st)
    `CHK("pll_ramping", 1'b0, ramp)
    mid_reset();
    hs_set = 8'h01;
    $display("test halt_hs masked done");
  endtask
  initial begin
    step(16);
    rst = 1'b0;
    step(1);
    t_reset();
    t_gate();
    t_stop();
    t_halt();
    t_halths();
    t_halths_masked();
    complete_run();
  end
endmodule
bind sbcrc_top sbcrc_chk u_chk (.sys_clk(sys_clk), .rst(rst), .wake_halt_irq(wake_halt_irq),
  .sel_hs_system_clock(sel_hs_system_clock), .run(run), .hs_osc_force_on(hs_osc_force_on), .hs_clk_avail(hs_clk_avail),
  .standby_state(standby_state), .periph_rst(periph_rst), .periph_wr_ok(periph_wr_ok), .periph_clk(periph_clk));
`default_nettype wire
